// ==== inc/rcs_cfg.svh ====
// constants of the rolling counter and device status bank
`ifndef RCS_CFG_SVH
`define RCS_CFG_SVH

// register offsets
`define RCS_OFS_COUNT 8'h00
`define RCS_OFS_TOP 8'h01
`define RCS_OFS_SUPPLY 8'h02
`define RCS_OFS_MEMTEMP 8'h03
`define RCS_OFS_LINK 8'h04

// widths
`define RCS_DATA_W 8
`define RCS_PRESC_W 10
`define RCS_TIMER_W 24

// prescaler divides the primary oscillator tick by 1000
`define RCS_PRESC_DIV 10'h3E8
`define RCS_PRESC_LAST 10'h3E7
`define RCS_PRESC_RST 10'h000
`define RCS_PRESC_STEP 10'h001
// resulting counter step in microseconds, for a 10 MHz oscillator tick
`define RCS_TICK_US 100

// top_status bit positions
`define RCS_TOP_PROC 7
`define RCS_TOP_LINK 5
`define RCS_TOP_MEMTEMP 4
`define RCS_TOP_SUPPLY 3
`define RCS_TOP_TEST 2
`define RCS_TOP_RESET 1
`define RCS_TOP_INIT 0

// supply_error_status bit positions
`define RCS_SUP_UV 7
`define RCS_SUP_AREG 3
`define RCS_SUP_DREG 2
`define RCS_SUP_MREG 1
`define RCS_SUP_CONT 0

// memory_temp_status bit positions
`define RCS_MT_FMEM 7
`define RCS_MT_UMEM 6
`define RCS_MT_UREG 5
`define RCS_MT_UWR 4
`define RCS_MT_TEMP 2

// link_error_status bit position
`define RCS_LINK_OUT 7

// reset values
`define RCS_BYTE_ZERO 8'h00
`define RCS_COUNT_RST 8'h00
`define RCS_COUNT_STEP 8'h01
`define RCS_PROC_RST 1'b1
`define RCS_LINK_RST 1'b0
`define RCS_MEMTEMP_RST 1'b0
`define RCS_SUPPLY_RST 1'b0
`define RCS_TEST_RST 1'b0
`define RCS_RESETF_RST 1'b1
`define RCS_INIT_RST 1'b1
`define RCS_TIMER_ZERO 24'h000000
`define RCS_TIMER_STEP 24'h000001

// default delays in mclk cycles (250 MHz): 1 ms and 100 us
`define RCS_POWERON_CYCLES_DEF 24'h03D090
`define RCS_RECOVERY_CYCLES_DEF 24'h0061A8

// synchronised monitor inputs, one bit each
`define RCS_SRC_W 14
`define RCS_SRC_ST_UNF 0
`define RCS_SRC_CM 1
`define RCS_SRC_ST_ERR 2
`define RCS_SRC_LINK 3
`define RCS_SRC_FMEM 4
`define RCS_SRC_UMEM 5
`define RCS_SRC_UREG 6
`define RCS_SRC_UWR 7
`define RCS_SRC_TEMP 8
`define RCS_SRC_UV 9
`define RCS_SRC_AREG 10
`define RCS_SRC_DREG 11
`define RCS_SRC_MREG 12
`define RCS_SRC_CONT 13
`define RCS_SRC_ZERO 14'h0000
// synchroniser reset: self-test counts as unfinished until real inputs arrive
`define RCS_SRC_RST 14'h0001

`endif

// ==== inc/rcs_pkg.sv ====
// types and helper functions of the status bank
`include "rcs_cfg.svh"
package rcs_pkg;

    typedef logic [`RCS_SRC_W-1:0] rcs_src_t;
    typedef logic [`RCS_DATA_W-1:0] rcs_byte_t;
    typedef logic [`RCS_TIMER_W-1:0] rcs_timer_t;

    typedef struct packed {
        logic [`RCS_PRESC_W-1:0] div;
        logic tick;
    } rcs_presc_state_t;

    typedef struct packed {
        rcs_src_t sync1;
        rcs_src_t sync2;
        rcs_byte_t count;
        logic proc_flag;
        logic link_flag;
        logic memtemp_flag;
        logic supply_flag;
        logic test_flag;
        logic reset_flag;
        logic init_flag;
        rcs_byte_t memtemp;
        rcs_byte_t supply;
        logic link_out;
        rcs_timer_t recovery;
        rcs_timer_t poweron;
        rcs_byte_t rd_data;
        logic rd_valid;
    } rcs_state_t;

    // set wins over clear
    function automatic rcs_byte_t rcs_sticky(input rcs_byte_t q, input rcs_byte_t set,
                                             input rcs_byte_t clr);
        rcs_sticky = (q & ~clr) | set;
    endfunction

    function automatic logic rcs_hit(input logic en, input rcs_byte_t addr,
                                     input rcs_byte_t ofs);
        rcs_hit = en && (addr == ofs);
    endfunction

endpackage

// ==== inc/rcs_tick_if.sv ====
// oscillator tick in, prescaled tick out
`timescale 1ns/10ps
interface rcs_tick_if;
    logic osc_tick;
    logic tick;
    modport src (output osc_tick, input tick);
    modport div (input osc_tick, output tick);
endinterface

// ==== core/rcs_prescaler.sv ====
// ten-bit prescaler producing the rolling counter step
`timescale 1ns/10ps
module rcs_prescaler
    import rcs_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    rcs_tick_if.div tk
);

    rcs_presc_state_t q;
    rcs_presc_state_t next_q;

    always_comb begin
        next_q = q;
        next_q.tick = 1'b0;
        if (tk.osc_tick) begin
            if (q.div == `RCS_PRESC_LAST) begin
                next_q.div = `RCS_PRESC_RST;
                next_q.tick = 1'b1;
            end else begin
                next_q.div = q.div + `RCS_PRESC_STEP;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign tk.tick = q.tick;

endmodule

// ==== core/rcs_status_regs.sv ====
// rolling counter and device status register bank
`timescale 1ns/10ps

// Behaviour
// - 8-bit counter steps once per 100 us and wraps to zero.
// - Counter step comes from a 10-bit prescaler dividing oscillator by 1000.
// - Rolling counter at offset 00h is read-only and resets to zero.
// - All status registers are read-only and readable through the one read port (rd_en, rd_addr).
// - Top bit 7 is OR of three signal-processor status bits; resets 1.
// - Top bit 5 follows the serial-output error bit; resets 0.
// - Top bit 4 is OR of five memory and temperature bits; resets 0.
// - Top bit 3 is OR of all supply and continuity error bits.
// - Top bit 2 shows test mode; cleared only by test operation or reset.
// - Top bit 1 set after reset; cleared by reading top or frame report.
// - Top bit 0 set after reset until sensor data becomes valid.
// - Supply bits share one recovery timer; clearing follows report disable.
// - Supply bit 7 set on supply undervoltage.
// - Supply bits 3, 2, 1 set on analog, digital, memory regulator faults.
// - Supply bit 0 set on continuity break; resets 0.
// - Memory and temperature bits, except live write bit 4, clear on own read or frame report.
module rcs_status_regs
    import rcs_pkg::*;
#(
    parameter rcs_timer_t POWERON_CYCLES = `RCS_POWERON_CYCLES_DEF,
    parameter rcs_timer_t RECOVERY_CYCLES = `RCS_RECOVERY_CYCLES_DEF
)
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic osc_tick,
    input wire logic selftest_unfinished,
    input wire logic common_mode_fault,
    input wire logic selftest_fault,
    input wire logic serial_out_fault,
    input wire logic factory_mem_fault,
    input wire logic user_mem_fault,
    input wire logic user_reg_fault,
    input wire logic user_write_active,
    input wire logic temperature_fault,
    input wire logic supply_undervoltage_fault,
    input wire logic analog_regulator_fault,
    input wire logic digital_regulator_fault,
    input wire logic memory_regulator_fault,
    input wire logic perimeter_continuity_fault,
    input wire logic test_mode_enter,
    input wire logic test_mode_exit,
    input wire logic supply_report_disable,
    input wire logic frame_report_reset,
    input wire logic frame_report_memtemp,
    input wire logic rd_en,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data,
    output logic rd_valid
);

    rcs_state_t q;
    rcs_state_t next_q;
    rcs_src_t src_raw;
    rcs_tick_if tk();

    rcs_prescaler u_presc (
        .mclk(mclk),
        .reset(reset),
        .tk(tk.div)
    );

    assign tk.osc_tick = osc_tick;

    // monitor inputs come from analog comparators, not this clock
    always_comb begin
        src_raw = `RCS_SRC_ZERO;
        src_raw[`RCS_SRC_ST_UNF] = selftest_unfinished;
        src_raw[`RCS_SRC_CM] = common_mode_fault;
        src_raw[`RCS_SRC_ST_ERR] = selftest_fault;
        src_raw[`RCS_SRC_LINK] = serial_out_fault;
        src_raw[`RCS_SRC_FMEM] = factory_mem_fault;
        src_raw[`RCS_SRC_UMEM] = user_mem_fault;
        src_raw[`RCS_SRC_UREG] = user_reg_fault;
        src_raw[`RCS_SRC_UWR] = user_write_active;
        src_raw[`RCS_SRC_TEMP] = temperature_fault;
        src_raw[`RCS_SRC_UV] = supply_undervoltage_fault;
        src_raw[`RCS_SRC_AREG] = analog_regulator_fault;
        src_raw[`RCS_SRC_DREG] = digital_regulator_fault;
        src_raw[`RCS_SRC_MREG] = memory_regulator_fault;
        src_raw[`RCS_SRC_CONT] = perimeter_continuity_fault;
    end

    rcs_src_t s;
    rcs_byte_t top_view;
    rcs_byte_t supply_live;
    rcs_byte_t memtemp_set;
    rcs_byte_t memtemp_clr;
    rcs_byte_t memtemp_next;
    rcs_byte_t supply_next;
    logic supply_any;
    logic rd_top;
    logic rd_memtemp;

    // synchronised copy, read only after the second stage
    assign s = q.sync2;

    always_comb begin
        top_view = `RCS_BYTE_ZERO;
        top_view[`RCS_TOP_PROC] = q.proc_flag;
        top_view[`RCS_TOP_LINK] = q.link_flag;
        top_view[`RCS_TOP_MEMTEMP] = q.memtemp_flag;
        top_view[`RCS_TOP_SUPPLY] = q.supply_flag;
        top_view[`RCS_TOP_TEST] = q.test_flag;
        top_view[`RCS_TOP_RESET] = q.reset_flag;
        top_view[`RCS_TOP_INIT] = q.init_flag;
    end

    // supply conditions as they stand this cycle, in register layout
    always_comb begin
        supply_live = `RCS_BYTE_ZERO;
        supply_live[`RCS_SUP_UV] = s[`RCS_SRC_UV];
        supply_live[`RCS_SUP_AREG] = s[`RCS_SRC_AREG];
        supply_live[`RCS_SUP_DREG] = s[`RCS_SRC_DREG];
        supply_live[`RCS_SUP_MREG] = s[`RCS_SRC_MREG];
        supply_live[`RCS_SUP_CONT] = s[`RCS_SRC_CONT];
    end

    assign supply_any = |supply_live;

    // sticky memory and temperature errors
    always_comb begin
        memtemp_set = `RCS_BYTE_ZERO;
        memtemp_set[`RCS_MT_FMEM] = s[`RCS_SRC_FMEM];
        memtemp_set[`RCS_MT_UMEM] = s[`RCS_SRC_UMEM];
        memtemp_set[`RCS_MT_UREG] = s[`RCS_SRC_UREG];
        memtemp_set[`RCS_MT_TEMP] = s[`RCS_SRC_TEMP];
    end

    assign rd_top = rcs_hit(rd_en, rd_addr, `RCS_OFS_TOP);
    assign rd_memtemp = rcs_hit(rd_en, rd_addr, `RCS_OFS_MEMTEMP);

    // cleared by own read or by a frame reporting them
    always_comb begin
        memtemp_clr = `RCS_BYTE_ZERO;
        if (rd_memtemp || frame_report_memtemp) begin
            memtemp_clr = ~`RCS_BYTE_ZERO;
        end
    end

    always_comb begin
        // set wins, so a standing fault returns at once
        memtemp_next = rcs_sticky(q.memtemp, memtemp_set, memtemp_clr);
        // write-in-progress is live, not sticky
        memtemp_next[`RCS_MT_UWR] = s[`RCS_SRC_UWR];
    end

    // shared recovery hold, or plain follow when reporting is disabled
    always_comb begin
        if (supply_report_disable) begin
            supply_next = supply_live;
        end else if (supply_any) begin
            supply_next = q.supply | supply_live;
        end else if (q.recovery == `RCS_TIMER_ZERO) begin
            supply_next = `RCS_BYTE_ZERO;
        end else begin
            supply_next = q.supply;
        end
    end

    always_comb begin
        next_q = q;

        // two-stage synchroniser
        next_q.sync1 = src_raw;
        next_q.sync2 = q.sync1;

        if (tk.tick) begin
            next_q.count = q.count + `RCS_COUNT_STEP;
        end

        next_q.proc_flag = s[`RCS_SRC_ST_UNF] | s[`RCS_SRC_CM] | s[`RCS_SRC_ST_ERR];

        next_q.link_out = s[`RCS_SRC_LINK];
        next_q.link_flag = q.link_out;

        next_q.memtemp = memtemp_next;
        next_q.memtemp_flag = |q.memtemp;

        // timer reloads while any supply fault stands
        if (supply_any) begin
            next_q.recovery = RECOVERY_CYCLES;
        end else if (q.recovery != `RCS_TIMER_ZERO) begin
            next_q.recovery = q.recovery - `RCS_TIMER_STEP;
        end
        next_q.supply = supply_next;
        next_q.supply_flag = |q.supply;

        // only a test operation or reset clears it
        if (test_mode_enter) begin
            next_q.test_flag = 1'b1;
        end else if (test_mode_exit) begin
            next_q.test_flag = 1'b0;
        end

        // cleared by top read or frame report
        if (rd_top || frame_report_reset) begin
            next_q.reset_flag = 1'b0;
        end

        // held until the data-valid delay runs out
        if (q.poweron != `RCS_TIMER_ZERO) begin
            next_q.poweron = q.poweron - `RCS_TIMER_STEP;
        end
        if (q.poweron == `RCS_TIMER_STEP) begin
            next_q.init_flag = 1'b0;
        end

        // read path, the single host read port
        next_q.rd_valid = rd_en;
        next_q.rd_data = `RCS_BYTE_ZERO;
        if (rd_en) begin
            case (rd_addr)
                `RCS_OFS_COUNT: begin
                    next_q.rd_data = q.count;
                end
                `RCS_OFS_TOP: begin
                    next_q.rd_data = top_view;
                end
                `RCS_OFS_SUPPLY: begin
                    next_q.rd_data = q.supply;
                end
                `RCS_OFS_MEMTEMP: begin
                    next_q.rd_data = q.memtemp;
                end
                `RCS_OFS_LINK: begin
                    next_q.rd_data[`RCS_LINK_OUT] = q.link_out;
                end
                default: begin
                    next_q.rd_data = `RCS_BYTE_ZERO;
                end
            endcase
        end
    end

    // reset stands in for power-on and soft reset alike
    always_ff @(posedge mclk) begin
        if (reset) begin
            // error flag holds
            // keeps bit 7 at its reset value until the inputs are through
            q.sync1 <= `RCS_SRC_RST;
            q.sync2 <= `RCS_SRC_RST;
            q.count <= `RCS_COUNT_RST;
            q.proc_flag <= `RCS_PROC_RST;
            q.link_flag <= `RCS_LINK_RST;
            q.memtemp_flag <= `RCS_MEMTEMP_RST;
            q.supply_flag <= `RCS_SUPPLY_RST;
            q.test_flag <= `RCS_TEST_RST;
            q.reset_flag <= `RCS_RESETF_RST;
            q.init_flag <= `RCS_INIT_RST;
            q.memtemp <= `RCS_BYTE_ZERO;
            q.supply <= `RCS_BYTE_ZERO;
            q.link_out <= 1'b0;
            q.recovery <= `RCS_TIMER_ZERO;
            q.poweron <= POWERON_CYCLES;
            q.rd_data <= `RCS_BYTE_ZERO;
            q.rd_valid <= 1'b0;
        end else begin
            q <= next_q;
        end
    end

    // no write port exists: nothing here can be written
    assign rd_data = q.rd_data;
    assign rd_valid = q.rd_valid;

endmodule

// ==== verif/rcs_status_regs_chk.sv ====
// read-port checks of the rolling counter and status bank
`timescale 1ns/10ps
module rcs_status_regs_chk
    import rcs_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic test_mode_enter,
    input wire logic test_mode_exit,
    input wire logic rd_en,
    input wire logic [7:0] rd_addr,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    sequence top_rd;
        rd_en && rd_addr == 8'h01;
    endsequence
    sequence enter_then_top;
        test_mode_enter ##1 !test_mode_exit ##1 top_rd;
    endsequence
    sequence exit_then_top;
        test_mode_exit && !test_mode_enter ##1 !test_mode_enter ##1 top_rd;
    endsequence

    rd_answer_a: assert property (rd_en |=> rd_valid)
        else $error("read not answered one cycle later");
    idle_quiet_a: assert property (!rd_en |=> !rd_valid && rd_data == 8'h00)
        else $error("read port active without a request");
    reset_quiet_a: assert property (disable iff (1'b0) reset |=> !rd_valid && !rd_data)
        else $error("read port active during reset");
    unmapped_zero_a: assert property (rd_en && rd_addr > 8'h04 |=> rd_data == 8'h00)
        else $error("unmapped offset returned nonzero");
    top_reserved_a: assert property (top_rd |=> !rd_data[6])
        else $error("top status reserved bit set");
    supply_reserved_a: assert property (rd_en && rd_addr == 8'h02 |=> !rd_data[6:4])
        else $error("supply status reserved bits set");
    reset_bit_clear_a: assert property (top_rd ##1 top_rd |=> !rd_data[1])
        else $error("reset flag survived a top status read");
    test_set_a: assert property (enter_then_top |=> rd_data[2])
        else $error("test flag not set after entry");
    test_clear_a: assert property (exit_then_top |=> !rd_data[2])
        else $error("test flag not cleared after exit");
endmodule

bind rcs_status_regs rcs_status_regs_chk chk (
    .mclk(mclk),
    .reset(reset),
    .test_mode_enter(test_mode_enter),
    .test_mode_exit(test_mode_exit),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_valid(rd_valid)
);

// ==== verif/rcs_host_model.sv ====
// host side model issuing register reads
`timescale 1ns/10ps
module rcs_host_model
    import rcs_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    output logic rd_en,
    output logic [7:0] rd_addr,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid
);
    initial begin
        rd_en = 1'b0;
        rd_addr = 8'h00;
    end

    task automatic rd(input rcs_byte_t a, output rcs_byte_t d, output logic v);
        while (reset) @(posedge mclk);
        @(posedge mclk);
        #1;
        rd_en = 1'b1;
        rd_addr = a;
        @(posedge mclk);
        #1;
        rd_en = 1'b0;
        // released address never shows the old value
        rd_addr = ~a;
        d = rd_data;
        v = rd_valid;
    endtask

    task automatic rd2(input rcs_byte_t a, output rcs_byte_t d1, output rcs_byte_t d2);
        @(posedge mclk);
        #1;
        rd_en = 1'b1;
        rd_addr = a;
        @(posedge mclk);
        #1;
        d1 = rd_data;
        @(posedge mclk);
        #1;
        rd_en = 1'b0;
        rd_addr = ~a;
        d2 = rd_data;
    endtask
endmodule

// ==== verif/rcs_status_regs_tb_top.sv ====
// self-checking bench of the status bank
`timescale 1ns/10ps
`include "rcs_cfg.svh"
`define RCS_EQ(got, exp) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) begin \
            n_errors++; \
            $display("BAD %0t got %h exp %h", $time, (got), (exp)); \
        end \
    end
module rcs_status_regs_tb_top
    import rcs_pkg::*;
;
    localparam rcs_byte_t TOP_BIT [14] = '{7, 7, 7, 5, 4, 4, 4, 4, 4, 3, 3, 3, 3, 3};
    localparam rcs_byte_t OWN_ADR [14] = '{1, 1, 1, 4, 3, 3, 3, 3, 3, 2, 2, 2, 2, 2};
    localparam rcs_byte_t OWN_BIT [14] = '{7, 7, 7, 7, 7, 6, 5, 4, 2, 7, 3, 2, 1, 0};
    // sources that latch until read
    localparam logic [13:0] STICKY = 14'h0170;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic osc_tick = 1'b0;
    logic [13:0] src = 14'h0000;
    logic test_mode_enter = 1'b0;
    logic test_mode_exit = 1'b0;
    logic supply_report_disable = 1'b0;
    logic frame_report_reset = 1'b0;
    logic frame_report_memtemp = 1'b0;
    logic rd_en;
    rcs_byte_t rd_addr;
    rcs_byte_t rd_data;
    logic rd_valid;
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #2 mclk = ~mclk;

    rcs_status_regs #(.POWERON_CYCLES(24'h000014), .RECOVERY_CYCLES(24'h00000A)) dut (
        .mclk(mclk), .reset(reset), .osc_tick(osc_tick),
        .selftest_unfinished(src[`RCS_SRC_ST_UNF]), .common_mode_fault(src[`RCS_SRC_CM]),
        .selftest_fault(src[`RCS_SRC_ST_ERR]), .serial_out_fault(src[`RCS_SRC_LINK]),
        .factory_mem_fault(src[`RCS_SRC_FMEM]), .user_mem_fault(src[`RCS_SRC_UMEM]),
        .user_reg_fault(src[`RCS_SRC_UREG]), .user_write_active(src[`RCS_SRC_UWR]),
        .temperature_fault(src[`RCS_SRC_TEMP]), .supply_undervoltage_fault(src[`RCS_SRC_UV]),
        .analog_regulator_fault(src[`RCS_SRC_AREG]),
        .digital_regulator_fault(src[`RCS_SRC_DREG]),
        .memory_regulator_fault(src[`RCS_SRC_MREG]),
        .perimeter_continuity_fault(src[`RCS_SRC_CONT]),
        .test_mode_enter(test_mode_enter), .test_mode_exit(test_mode_exit),
        .supply_report_disable(supply_report_disable),
        .frame_report_reset(frame_report_reset), .frame_report_memtemp(frame_report_memtemp),
        .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid));

    rcs_host_model host (.mclk(mclk), .reset(reset), .rd_en(rd_en), .rd_addr(rd_addr),
        .rd_data(rd_data), .rd_valid(rd_valid));

    task automatic stop_test();
        $display("checked %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            n_errors++;
            stop_test();
        end
    end

    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic rdc(input rcs_byte_t a, input rcs_byte_t e);
        rcs_byte_t d;
        logic v;
        host.rd(a, d, v);
        `RCS_EQ({v, d}, {1'b1, e})
    endtask

    task automatic pulses(input int n);
        repeat (n) begin
            osc_tick = 1'b1;
            wt(1);
            osc_tick = 1'b0;
            wt(1);
        end
    endtask

    task automatic t_after_reset();
        rcs_byte_t d1;
        rcs_byte_t d2;
        host.rd2(8'h01, d1, d2);
        `RCS_EQ(d1, 8'h83)
        `RCS_EQ(d2, 8'h81)
        `RCS_EQ(d1[7], 1'b1)
        rdc(8'h00, 8'h00);
        rdc(8'h02, 8'h00);
        rdc(8'h05, 8'h00);
        rdc(8'hFF, 8'h00);
        rdc(8'h01, 8'h01);
        wt(20);
        rdc(8'h01, 8'h00);
    endtask

    task automatic t_counter();
        pulses(999);
        wt(3);
        rdc(8'h00, 8'h00);
        pulses(1);
        wt(3);
        rdc(8'h00, 8'h01);
        pulses(1000);
        wt(3);
        rdc(8'h00, 8'h02);
    endtask

    task automatic t_test();
        for (int k = 0; k < 4; k++) begin
            test_mode_enter = (k != 1 && k != 3);
            test_mode_exit = (k != 0);
            wt(1);
            test_mode_enter = 1'b0;
            test_mode_exit = 1'b0;
            rdc(8'h01, (k == 0 || k == 2) ? 8'h04 : 8'h00);
        end
    endtask

    task automatic t_faults();
        for (int i = 0; i < 14; i++) begin
            src = 14'h0001 << i;
            wt(5);
            rdc(8'h01, 8'h01 << TOP_BIT[i]);
            rdc(OWN_ADR[i], 8'h01 << OWN_BIT[i]);
            rdc(OWN_ADR[i], 8'h01 << OWN_BIT[i]);
            src = 14'h0000;
            wt(3);
            if (OWN_ADR[i] == 8'h02) begin
                rdc(8'h02, 8'h01 << OWN_BIT[i]);
            end
            wt(20);
            rdc(OWN_ADR[i], STICKY[i] ? 8'h01 << OWN_BIT[i] : 8'h00);
            rdc(OWN_ADR[i], 8'h00);
            rdc(8'h01, 8'h00);
        end
    endtask

    task automatic t_clears();
        rcs_byte_t d;
        logic v;
        src = 14'h0001 << `RCS_SRC_TEMP;
        wt(5);
        src = 14'h0000;
        wt(4);
        frame_report_memtemp = 1'b1;
        wt(1);
        frame_report_memtemp = 1'b0;
        rdc(8'h03, 8'h00);
        supply_report_disable = 1'b1;
        src = 14'h0001 << `RCS_SRC_UV;
        wt(5);
        rdc(8'h02, 8'h80);
        src = 14'h0000;
        wt(4);
        rdc(8'h02, 8'h00);
        reset = 1'b1;
        wt(2);
        reset = 1'b0;
        frame_report_reset = 1'b1;
        wt(1);
        frame_report_reset = 1'b0;
        host.rd(8'h01, d, v);
        `RCS_EQ(d[1], 1'b0)
        `RCS_EQ(d[0], 1'b1)
        `RCS_EQ(d[7], 1'b1)
        `RCS_EQ(d[2], 1'b0)
    endtask

    initial begin
        repeat (16) @(posedge mclk);
        #1;
        reset = 1'b0;
        t_after_reset();
        t_counter();
        t_test();
        t_faults();
        t_clears();
        stop_test();
    end
endmodule
